// *** logic/afe_ctrl_pkg.sv ***
// afe_ctrl_pkg: constants and types for the front-end control register bank.
// assumes: control words arrive already deserialised, 16 bits, on core_clk.
package afe_ctrl_pkg;

   // register indices (3-bit register field of a control word)
   localparam logic [2:0] REG_A = 3'h0;        // serial_port_mode_control
   localparam logic [2:0] REG_B = 3'h1;        // clock_rate_control
   localparam logic [2:0] REG_C = 3'h2;        // reference_power_control
   localparam logic [2:0] REG_D = 3'h3;        // channel12_gain_power
   localparam logic [2:0] REG_E = 3'h4;        // channel34_gain_power
   localparam logic [2:0] REG_F = 3'h5;        // channel56_gain_power
   localparam logic [2:0] REG_G = 3'h6;        // input_config_modulator_reset
   localparam logic [2:0] REG_H = 3'h7;        // channel_inversion_control
   localparam int         NUM_REGS = 8;
   localparam logic [7:0] REG_RESET = 8'h00;

   // control word layout
   localparam int CW_CONTROL = 15;
   localparam int CW_READ    = 14;
   localparam int CW_DEV_HI  = 13;
   localparam int CW_DEV_LO  = 11;
   localparam int CW_REG_HI  = 10;
   localparam int CW_REG_LO  = 8;
   localparam int CW_DAT_HI  = 7;

   // register a fields
   localparam int A_OPERATING_MODE = 0;
   localparam int A_MIXED_MODE     = 1;
   localparam int A_LOOPBACK       = 3;
   localparam int A_COUNT_LO       = 4;
   localparam int A_COUNT_HI       = 6;
   localparam int A_SOFT_RESET     = 7;
   // register b fields
   localparam int B_DECIM_LO = 0;
   localparam int B_DECIM_HI = 1;
   localparam int B_SCLK_LO  = 2;
   localparam int B_SCLK_HI  = 3;
   localparam int B_MCLK_LO  = 4;
   localparam int B_MCLK_HI  = 6;
   localparam int B_ECHO     = 7;
   // register c fields
   localparam int C_GLOBAL_POWER = 0;
   localparam int C_REF_POWER    = 5;
   localparam int C_REF_OUT      = 6;
   localparam int C_HIGH_SUPPLY  = 7;
   // registers d..f: two channels per register
   localparam int PAIR_GAIN_LO  = 0;
   localparam int PAIR_GAIN_HI  = 2;
   localparam int PAIR_POWER    = 3;
   localparam int PAIR_STRIDE   = 4;
   // registers g and h
   localparam int SEL_HI        = 5;
   localparam int G_MOD_RESET   = 6;
   localparam int G_SINGLE_END  = 7;
   localparam int H_TEST_MODE   = 6;
   localparam int H_INVERT      = 7;

   localparam int NUM_CH       = 6;
   localparam int SW_RESET_CYC = 4;            // soft reset hold, in clocks

   typedef enum logic [1:0] {
      MODE_PROGRAM = 2'b00,
      MODE_DATA    = 2'b01,
      MODE_MIXED   = 2'b11
   } op_mode_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } ctrl_word_t;

   typedef struct packed {
      op_mode_t                 operating_mode_select;
      logic                     serial_port_loopback;
      logic [2:0]               device_count;
      logic                     control_echo_enable;
      logic [1:0]               decimation_code;
      logic [1:0]               serial_clock_div;
      logic [2:0]               master_clock_div;
      logic                     reference_power;
      logic                     reference_output_enable;
      logic                     high_supply_mode;
      logic                     test_mode_enable;
      logic [NUM_CH-1:0]        adc_power_on;
      logic [NUM_CH-1:0][2:0]   adc_gain;
      logic [NUM_CH-1:0]        modulator_reset;
      logic [NUM_CH-1:0]        single_ended;
      logic [NUM_CH-1:0]        polarity_flip;
   } afe_ctrl_t;

endpackage : afe_ctrl_pkg

// *** logic/afe_ctrl_regs.sv ***
// afe_ctrl_regs: eight 8-bit control registers of a six-channel adc front end,
// written and read through 16-bit control words from the serial port, with the
// decoded controls driven out to the converter, reference and clock logic.
// assumes: the serial port shifter runs on core_clk and hands over one whole
// word per ctrl_in.valid pulse; outgoing words are shifted out by that shifter.
//
// Notes on behaviour
// - mixed clear: bit0 picks program or data
// - mixed bit set forces mixed mode
// - bit3 enables serial loop-back diagnostic
// - bits 6:4 hold cascade device count
// - writing bit7 one starts software reset
// - register b 1:0 decimation code
// - register b 3:2 serial clock divider code
// - register b 6:4 master clock divider code
// - echo bit resends each write word addressed to this device
// - global power-up powers all six channels
// - register c bit5 powers reference
// - register c bit6 enables reference output pin
// - register c bit7 selects 5 V mode
// - d,e,f hold two 3-bit channel gains
// - bits 3 and 7 power each channel
// - g holds selects, modulator reset, single-ended
// - h holds selects, test mode, invert
// - selected channels reset or made single-ended
// - selected channels inverted when invert enabled
// - any reset clears every register to zero
`timescale 1ns/1ps

module afe_ctrl_regs
   import afe_ctrl_pkg::*;
#(
   parameter int unsigned SW_RESET_CYCLES = SW_RESET_CYC
)
(
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire afe_ctrl_pkg::ctrl_word_t ctrl_in,
   output      afe_ctrl_pkg::ctrl_word_t ctrl_out,
   output      afe_ctrl_pkg::afe_ctrl_t  ctrl,
   output      logic                   soft_reset_busy
);
   import afe_ctrl_pkg::*;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] bank;
      afe_ctrl_t                ctrl;
      ctrl_word_t               tx;
      logic [7:0]               rst_cnt;
      logic                     busy;
   } state_t;

   state_t s_q;
   state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // control word decode

   logic       hit;
   logic       for_me;
   logic       busy;
   logic [2:0] dev_addr;
   logic [2:0] reg_addr;
   logic [7:0] wdata;
   logic [NUM_REGS-1:0][7:0] bank_n;

   // words with the control flag low are ignored; in program mode they carry
   // no meaning and in data mode they are sample slots, not commands
   assign busy     = s_q.busy;
   assign hit      = ctrl_in.valid && ctrl_in.word[CW_CONTROL] && !busy;
   assign dev_addr = ctrl_in.word[CW_DEV_HI:CW_DEV_LO];
   assign reg_addr = ctrl_in.word[CW_REG_HI:CW_REG_LO];
   assign wdata    = ctrl_in.word[CW_DAT_HI:0];
   assign for_me   = hit && (dev_addr == 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // per-channel decode of the next register image

   logic [NUM_CH-1:0]      pwr_n;
   logic [NUM_CH-1:0][2:0] gain_n;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1)
      begin : g_chan
         // two channels share a register: even index low nibble, odd high
         localparam logic [2:0] RIDX = 3'(REG_D + ch / 2);
         localparam int         BASE = (ch % 2) * PAIR_STRIDE;
         assign gain_n[ch] = bank_n[RIDX][BASE + PAIR_GAIN_HI:BASE + PAIR_GAIN_LO];
         assign pwr_n[ch]  = bank_n[RIDX][BASE + PAIR_POWER]
                             | bank_n[REG_C][C_GLOBAL_POWER];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      s_d        = s_q;
      s_d.tx     = '0;
      bank_n     = s_q.bank;

      if (busy)
      begin
         s_d.rst_cnt = s_q.rst_cnt - 8'h01;
      end

      if (hit && (dev_addr != 3'h0))
      begin
         // addressed further down the cascade: pass on with address less one
         s_d.tx.valid                      = 1'b1;
         s_d.tx.word                       = ctrl_in.word;
         s_d.tx.word[CW_DEV_HI:CW_DEV_LO]  = dev_addr - 3'h1;
      end
      else if (for_me && ctrl_in.word[CW_READ])
      begin
         // read: selected register replaces the data field and goes out
         s_d.tx.valid               = 1'b1;
         s_d.tx.word                = ctrl_in.word;
         s_d.tx.word[CW_DAT_HI:0]   = s_q.bank[reg_addr];
      end
      else if (for_me)
      begin
         if ((reg_addr == REG_A) && wdata[A_SOFT_RESET])
         begin
            // soft reset: all registers to zero, words refused meanwhile
            bank_n      = {NUM_REGS{REG_RESET}};
            s_d.rst_cnt = 8'(SW_RESET_CYCLES);
         end
         else
         begin
            bank_n[reg_addr] = wdata;
         end
         if (s_q.bank[REG_B][B_ECHO])
         begin
            s_d.tx.valid = 1'b1;
            s_d.tx.word  = ctrl_in.word;
         end
      end

      s_d.bank = bank_n;
      s_d.busy = (s_d.rst_cnt != 8'h00);                     // kept in a flop so the busy output is registered

      // decoded controls follow the new image in the same edge
      if (bank_n[REG_A][A_MIXED_MODE])
         s_d.ctrl.operating_mode_select = MODE_MIXED;
      else if (bank_n[REG_A][A_OPERATING_MODE])
         s_d.ctrl.operating_mode_select = MODE_DATA;
      else
         s_d.ctrl.operating_mode_select = MODE_PROGRAM;
      s_d.ctrl.serial_port_loopback    = bank_n[REG_A][A_LOOPBACK];
      s_d.ctrl.device_count            = bank_n[REG_A][A_COUNT_HI:A_COUNT_LO];
      s_d.ctrl.decimation_code         = bank_n[REG_B][B_DECIM_HI:B_DECIM_LO];
      s_d.ctrl.serial_clock_div        = bank_n[REG_B][B_SCLK_HI:B_SCLK_LO];
      s_d.ctrl.master_clock_div        = bank_n[REG_B][B_MCLK_HI:B_MCLK_LO];
      s_d.ctrl.control_echo_enable     = bank_n[REG_B][B_ECHO];
      s_d.ctrl.reference_power         = bank_n[REG_C][C_REF_POWER];
      s_d.ctrl.reference_output_enable = bank_n[REG_C][C_REF_OUT];
      s_d.ctrl.high_supply_mode        = bank_n[REG_C][C_HIGH_SUPPLY];
      s_d.ctrl.adc_power_on            = pwr_n;
      s_d.ctrl.adc_gain                = gain_n;
      s_d.ctrl.modulator_reset         = bank_n[REG_G][SEL_HI:0]
                                         & {NUM_CH{bank_n[REG_G][G_MOD_RESET]}};
      s_d.ctrl.single_ended            = bank_n[REG_G][SEL_HI:0]
                                         & {NUM_CH{bank_n[REG_G][G_SINGLE_END]}};
      s_d.ctrl.test_mode_enable        = bank_n[REG_H][H_TEST_MODE];
      s_d.ctrl.polarity_flip           = bank_n[REG_H][SEL_HI:0]
                                         & {NUM_CH{bank_n[REG_H][H_INVERT]}};
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; hardware reset clears the whole bank

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign ctrl_out        = s_q.tx;
   assign ctrl            = s_q.ctrl;
   assign soft_reset_busy = busy;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_program_mode;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && reg_addr == REG_A && wdata[2:0] == 3'h0 && !wdata[A_SOFT_RESET])
      |=> ctrl.operating_mode_select == MODE_PROGRAM;
   endproperty
   a_program_mode: assert property (p_program_mode) else $error("mode not program");

   property p_mixed_mode;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && reg_addr == REG_A && wdata[A_MIXED_MODE] && !wdata[A_SOFT_RESET])
      |=> ctrl.operating_mode_select == MODE_MIXED;
   endproperty
   a_mixed_mode: assert property (p_mixed_mode) else $error("mixed mode not taken");

   property p_soft_reset;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && reg_addr == REG_A && wdata[A_SOFT_RESET])
      |=> (ctrl == '0 && soft_reset_busy) [*4] ##1 !soft_reset_busy;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

   property p_global_power;
      @(posedge core_clk) disable iff (!nrst)
      s_q.bank[REG_C][C_GLOBAL_POWER] |-> ctrl.adc_power_on == 6'h3f;
   endproperty
   a_global_power: assert property (p_global_power) else $error("global power ignored");

   property p_gain_write;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && reg_addr == REG_D)
      |=> ctrl.adc_gain[0] == $past(wdata[2:0]) && ctrl.adc_gain[1] == $past(wdata[6:4]);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain not updated");

   property p_single_ended;
      @(posedge core_clk) disable iff (!nrst)
      !s_q.bank[REG_G][G_SINGLE_END] |-> ctrl.single_ended == 6'h00;
   endproperty
   a_single_ended: assert property (p_single_ended) else $error("single-ended leak");

   property p_invert;
      @(posedge core_clk) disable iff (!nrst)
      !s_q.bank[REG_H][H_INVERT] |-> ctrl.polarity_flip == 6'h00;
   endproperty
   a_invert: assert property (p_invert) else $error("inversion leak");

   property p_echo;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && ctrl.control_echo_enable)
      |=> ctrl_out.valid && ctrl_out.word == $past(ctrl_in.word);
   endproperty
   a_echo: assert property (p_echo) else $error("echo missing");

   property p_write_effect;
      @(posedge core_clk) disable iff (!nrst)
      (for_me && !ctrl_in.word[CW_READ] && reg_addr == REG_C)
      |=> ctrl.reference_power == $past(wdata[C_REF_POWER]) && ctrl.high_supply_mode == $past(wdata[C_HIGH_SUPPLY]);
   endproperty
   a_write_effect: assert property (p_write_effect) else $error("late write effect");

   // a write taken for this device, used by the checks below
   logic wr_hit;
   assign wr_hit = for_me && !ctrl_in.word[CW_READ];

   property p_loopback_count;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_A && !wdata[A_SOFT_RESET])
      |=> ctrl.serial_port_loopback == $past(wdata[A_LOOPBACK])
          && ctrl.device_count == $past(wdata[A_COUNT_HI:A_COUNT_LO]);
   endproperty
   a_loopback_count: assert property (p_loopback_count) else $error("loop-back or count wrong");

   property p_clock_codes;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_B)
      |=> ctrl.decimation_code == $past(wdata[B_DECIM_HI:B_DECIM_LO])
          && ctrl.serial_clock_div == $past(wdata[B_SCLK_HI:B_SCLK_LO])
          && ctrl.master_clock_div == $past(wdata[B_MCLK_HI:B_MCLK_LO]);
   endproperty
   a_clock_codes: assert property (p_clock_codes) else $error("clock codes wrong");

   property p_ref_output;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_C)
      |=> ctrl.reference_output_enable == $past(wdata[C_REF_OUT]);
   endproperty
   a_ref_output: assert property (p_ref_output) else $error("reference output enable wrong");

   property p_chan_power;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_D && !s_q.bank[REG_C][C_GLOBAL_POWER])
      |=> ctrl.adc_power_on[1:0] == {$past(wdata[PAIR_STRIDE + PAIR_POWER]), $past(wdata[PAIR_POWER])};
   endproperty
   a_chan_power: assert property (p_chan_power) else $error("channel power wrong");

   property p_mod_reset;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_G)
      |=> ctrl.modulator_reset == ($past(wdata[G_MOD_RESET]) ? $past(wdata[SEL_HI:0]) : 6'h00);
   endproperty
   a_mod_reset: assert property (p_mod_reset) else $error("modulator reset wrong");

   property p_polarity_write;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_H)
      |=> ctrl.polarity_flip == ($past(wdata[H_INVERT]) ? $past(wdata[SEL_HI:0]) : 6'h00);
   endproperty
   a_polarity_write: assert property (p_polarity_write) else $error("inversion wrong");

   property p_test_mode;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && reg_addr == REG_H)
      |=> ctrl.test_mode_enable == $past(wdata[H_TEST_MODE]);
   endproperty
   a_test_mode: assert property (p_test_mode) else $error("test mode wrong");

   property p_pass_on;
      @(posedge core_clk) disable iff (!nrst)
      (hit && dev_addr != 3'h0)
      |=> ctrl_out.valid && ctrl_out.word == {$past(ctrl_in.word[CW_CONTROL:CW_READ]), 3'($past(dev_addr) - 3'h1),
                                              $past(ctrl_in.word[CW_REG_HI:0])};
   endproperty
   a_pass_on: assert property (p_pass_on) else $error("cascade pass-on wrong");

   property p_refused;
      @(posedge core_clk) disable iff (!nrst)
      (busy && ctrl_in.valid)
      |=> !ctrl_out.valid && ctrl == '0;
   endproperty
   a_refused: assert property (p_refused) else $error("word taken during soft reset");

   // looked at one edge late so that state has settled after an early reset
   property p_hw_reset;
      @(posedge core_clk)
      !nrst |=> ctrl == '0 && !soft_reset_busy && !ctrl_out.valid;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("hardware reset not clean");

   property p_echo_off;
      @(posedge core_clk) disable iff (!nrst)
      (wr_hit && !ctrl.control_echo_enable)
      |=> !ctrl_out.valid;
   endproperty
   a_echo_off: assert property (p_echo_off) else $error("echo without echo bit");

   property p_control_flag;
      @(posedge core_clk) disable iff (!nrst)
      (ctrl_in.valid && !ctrl_in.word[CW_CONTROL])
      |=> !ctrl_out.valid && $stable(ctrl);
   endproperty
   a_control_flag: assert property (p_control_flag) else $error("non-control word acted on");

endmodule : afe_ctrl_regs

// *** verif/host_dsp_model.sv ***
// host_dsp_model: host side of the control word port, one whole word per send call.
// assumes: one caller at a time; words are sampled by the register bank on core_clk.
`timescale 1ns/1ps

module host_dsp_model
(
   input  wire logic                     core_clk,
   input  wire logic                     nrst,
   input  wire logic                     soft_reset_busy,
   output afe_ctrl_pkg::ctrl_word_t      ctrl_in
);
   import afe_ctrl_pkg::*;

   int stalls;                          // waits that ran out; the bench counts them as mismatches

   initial
   begin
      ctrl_in = '0;
      stalls  = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // gap idles first so the host can be slow as well as prompt; raw skips the
   // busy wait so a word can land inside the soft reset hold on purpose
   task automatic send(input logic [15:0] w, input bit raw, input int gap);
      int n;
      n = 0;
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      #1;
      while ((nrst !== 1'b1 || (soft_reset_busy === 1'b1 && !raw)) && n < 64)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 64)
         stalls++;
      if (w[15:8] == {5'b10000, REG_A}) w[2] = 1'b0;
      if (w[15:8] == {5'b10000, REG_C}) w[4:1] = 4'h0;
      @(posedge core_clk);
      ctrl_in <= '{valid: 1'b1, word: w};
      @(posedge core_clk);
      ctrl_in <= '0;
   endtask : send

endmodule : host_dsp_model

// *** verif/testbench.sv ***
// testbench: self-checking bench for the control register bank, one task per scenario.
// assumes: host_dsp_model delivers control words; design assertions run inside the design.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, g, e); end end

module testbench;
   import afe_ctrl_pkg::*;

   localparam int SW_CYC = 4;         // raw refusal below needs the hold to last at least 3 clocks
   logic       core_clk;
   logic       nrst;
   ctrl_word_t ctrl_in;
   ctrl_word_t ctrl_out;
   afe_ctrl_t  ctrl;
   logic       soft_reset_busy;
   int         fail_count;
   int         samples_checked;

   afe_ctrl_regs #(.SW_RESET_CYCLES(SW_CYC)) i_dut (
      .core_clk        (core_clk),
      .nrst            (nrst),
      .ctrl_in         (ctrl_in),
      .ctrl_out        (ctrl_out),
      .ctrl            (ctrl),
      .soft_reset_busy (soft_reset_busy)
   );

   host_dsp_model i_host (
      .core_clk        (core_clk),
      .nrst            (nrst),
      .soft_reset_busy (soft_reset_busy),
      .ctrl_in         (ctrl_in)
   );

   always #2.5 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // bus helpers: results are looked at 1 ns after the edge that takes the word
   task automatic wr(input logic [2:0] r, input logic [7:0] d, input int gap = 0);
      i_host.send({5'b10000, r, d}, 1'b0, gap);
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] r, output ctrl_word_t q);
      i_host.send({5'b11000, r, 8'h00}, 1'b0, 0);
      #1;
      q = ctrl_out;
   endtask : rd

   task automatic print_verdict();
      fail_count = fail_count + i_host.stalls;
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      ctrl_word_t q;
      `CHK(ctrl, afe_ctrl_t'(0))
      for (int r = 0; r < NUM_REGS; r++)
      begin
         rd(3'(r), q);
         `CHK(q, {1'b1, 5'b11000, 3'(r), REG_RESET})
      end
   endtask : t_reset

   task automatic t_mode();
      logic [7:0] d [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
      op_mode_t   m [4] = '{MODE_PROGRAM, MODE_DATA, MODE_MIXED, MODE_MIXED};
      ctrl_word_t q;
      for (int i = 0; i < 4; i++)
      begin
         wr(REG_A, d[i], i);
         `CHK(ctrl.operating_mode_select, m[i])
      end
      wr(REG_A, 8'h5c);
      `CHK(ctrl.serial_port_loopback, 1'b1)
      `CHK(ctrl.device_count, 3'h5)
      rd(REG_A, q);
      `CHK(q, {1'b1, 16'hc058})
   endtask : t_mode

   // echo follows the echo bit as it stood before each word; reads never echo
   task automatic t_clock();
      ctrl_word_t q;
      wr(REG_B, 8'h6d);
      `CHK(ctrl.decimation_code, 2'h1)
      `CHK(ctrl.serial_clock_div, 2'h3)
      `CHK(ctrl.master_clock_div, 3'h6)
      wr(REG_B, 8'h80);
      `CHK(ctrl_out.valid, 1'b0)
      wr(REG_G, 8'h00);
      `CHK(ctrl_out, {1'b1, 16'h8600})
      rd(REG_B, q);
      `CHK(q, {1'b1, 16'hc180})
      wr(REG_B, 8'h00);
      `CHK(ctrl_out, {1'b1, 16'h8100})
      `CHK(ctrl.control_echo_enable, 1'b0)
      // a word for the third device down is passed on with its address less one
      i_host.send(16'h9a55, 1'b0, 0);
      #1;
      `CHK(ctrl_out, {1'b1, 16'h9255})
      `CHK(ctrl.reference_output_enable, 1'b0)
      // a word without the control flag must not write register c
      i_host.send(16'h0241, 1'b0, 0);
      #1;
      `CHK({ctrl_out.valid, ctrl.reference_output_enable, ctrl.adc_power_on}, 8'h00)
   endtask : t_clock

   task automatic t_power();
      ctrl_word_t q;
      wr(REG_D, 8'h9a);
      wr(REG_E, 8'h5c);
      wr(REG_F, 8'ha7);
      `CHK(ctrl.adc_gain, {3'h2, 3'h7, 3'h5, 3'h4, 3'h1, 3'h2})
      `CHK(ctrl.adc_power_on, 6'h27)
      wr(REG_C, 8'hff);
      `CHK(ctrl.adc_power_on, 6'h3f)
      `CHK({ctrl.high_supply_mode, ctrl.reference_output_enable, ctrl.reference_power}, 3'h7)
      rd(REG_C, q);
      `CHK(q, {1'b1, 16'hc2e1})
      wr(REG_C, 8'h40); // global power off, per-channel bits only
      `CHK(ctrl.adc_power_on, 6'h27)
      `CHK({ctrl.high_supply_mode, ctrl.reference_output_enable, ctrl.reference_power}, 3'h2)
   endtask : t_power

   task automatic t_chan();
      logic [7:0]  g [3] = '{8'h55, 8'haa, 8'h3f};
      logic [11:0] e [3] = '{12'h540, 12'h02a, 12'h000};
      for (int i = 0; i < 3; i++)
      begin
         wr(REG_G, g[i]);
         `CHK({ctrl.modulator_reset, ctrl.single_ended}, e[i])
      end
      wr(REG_H, 8'ha3);
      `CHK({ctrl.test_mode_enable, ctrl.polarity_flip}, 7'h23)
      wr(REG_H, 8'h63);
      `CHK({ctrl.test_mode_enable, ctrl.polarity_flip}, 7'h40)
      wr(REG_H, 8'h00); // test mode back off for normal operation
      `CHK(ctrl.test_mode_enable, 1'b0)
   endtask : t_chan

   // a word pushed into the hold must be dropped; a hardware reset mid-run clears all
   task automatic t_soft();
      ctrl_word_t q;
      int         n;
      wr(REG_A, 8'h80);
      `CHK({soft_reset_busy, ctrl}, {1'b1, afe_ctrl_t'(0)})
      i_host.send(16'h8201, 1'b1, 0);
      #1;
      n = 3;
      while (soft_reset_busy === 1'b1 && n < 40)
      begin
         n++;
         @(posedge core_clk);
         #1;
      end
      if (n >= 40)
         fail_count++;
      `CHK(n, SW_CYC)
      `CHK(ctrl.adc_power_on, 6'h00)
      rd(REG_A, q);
      `CHK(q, {1'b1, 16'hc000})
      wr(REG_A, 8'h01);
      `CHK({soft_reset_busy, ctrl.operating_mode_select}, {1'b0, MODE_DATA})
      wr(REG_C, 8'h01);
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK({soft_reset_busy, ctrl}, {1'b0, afe_ctrl_t'(0)})
      @(posedge core_clk);
      nrst <= 1'b1;
      rd(REG_C, q);
      `CHK(q, {1'b1, 16'hc200})
   endtask : t_soft

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      nrst = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset();
      t_mode();
      t_clock();
      t_power();
      t_chan();
      t_soft();
      print_verdict();
   end

endmodule : testbench
